// [logic/exec_core.sv]
`timescale 1ns/1ps
`include "exec_cfg.svh"

// Operation
// - single watchdog clear resets counter, clears flags
// - both preclears together clear watchdog and flags
// - lone preclear only sets its marker
// - second preclear mirrors first preclear
// - complement memory byte in place, zero only
// - complement into accumulator, memory kept, zero
// - low nibble adjust, internal carry from inverted aux
// - high nibble adjust with internal carry, carry
// - adjust result to memory, only carry changes
// - decrement in place or to accumulator, zero
// - increment in place or to accumulator, zero
// - halt stops, clears watchdog, sets powerdown flag
// - jump loads address, no flags
// - moves copy data, no flags
// - no-operation only advances program counter
// - or to accumulator or memory, zero
// - return pops program counter, two cycles
// - return with value loads accumulator too
// - interrupt return sets global interrupt enable
// - rotate memory left, bit 7 to 0
// - rotate left into accumulator, memory kept
module exec_core
  import exec_pkg::*;
(
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // decoded instruction request
  input wire logic I_OP_VALID,
  input wire instr_t I_OP,
  output logic O_OP_READY,
  // data memory port, read byte of the addressed location
  input wire logic [`EXEC_DATA_W-1:0] I_MEM_RDATA,
  output logic O_MEM_WE,
  output logic [`EXEC_DATA_W-1:0] O_MEM_WDATA,
  // call logic outside pushes return addresses
  input wire logic I_STACK_PUSH,
  input wire logic [`EXEC_PC_W-1:0] I_STACK_PUSH_PC,
  // wake-up pin, asynchronous
  input wire logic I_WAKE,
  // interrupt controller clears the global enable on entry
  input wire logic I_GIE_CLEAR,
  // state outputs
  output logic [`EXEC_PC_W-1:0] O_PC,
  output logic [`EXEC_DATA_W-1:0] O_ACC,
  output status_t O_STATUS,
  output logic O_GLOBAL_INTERRUPT_ENABLE,
  output logic O_SYSCLK_RUN,
  output logic O_WATCHDOG_TIMEOUT,
  output logic [`EXEC_WDT_W-1:0] O_WATCHDOG_COUNTER,
  output logic [1:0] O_PRECLEAR_MARKS
);

  ////////////////////////////////////////////////////////////////////////
  // state
  state_t state; // sequencer state
  logic [`EXEC_PC_W-1:0] pc; // program counter
  logic [`EXEC_DATA_W-1:0] acc; // accumulator
  status_t status; // flags
  logic gie; // global interrupt enable
  logic mark_first; // first preclear seen
  logic mark_second; // second preclear seen
  logic [`EXEC_WDT_PRE_W-1:0] wdt_pre; // watchdog prescaler
  logic [`EXEC_WDT_W-1:0] watchdog_counter; // watchdog count
  logic wake_meta; // wake synchroniser, first stage
  logic wake_sync; // wake synchroniser, second stage
  logic mem_we; // registered memory strobe
  logic [`EXEC_DATA_W-1:0] mem_wdata; // registered memory data
  logic [`EXEC_PC_W-1:0] stack_data; // popped return address

  ////////////////////////////////////////////////////////////////////////
  // request decode
  wire take = I_OP_VALID & (state == ST_EXEC); // request accepted
  wire op_t op = I_OP.op;
  wire [`EXEC_DATA_W-1:0] m = I_MEM_RDATA; // addressed byte
  wire [`EXEC_DATA_W-1:0] x = I_OP.imm; // immediate
  wire is_ret = (op == OP_SUBROUTINE_RETURN) | (op == OP_RETURN_WITH_VALUE) |
                (op == OP_INTERRUPT_RETURN);
  wire pop = take & is_ret; // stack read for any return
  wire is_halt = take & (op == OP_HALT);
  wire is_single = take & (op == OP_WATCHDOG_CLEAR_SINGLE);
  wire is_pre1 = take & (op == OP_WATCHDOG_PRECLEAR_FIRST);
  wire is_pre2 = take & (op == OP_WATCHDOG_PRECLEAR_SECOND);
  // pair completes when the partner marker is already set
  wire pair_done = (is_pre1 & mark_second) | (is_pre2 & mark_first);
  wire wdt_clear = is_single | pair_done | is_halt;

  ////////////////////////////////////////////////////////////////////////
  // datapath results
  wire [`EXEC_DATA_W-1:0] r_cpl = ~m;
  wire [`EXEC_DATA_W-1:0] r_dec = m - 8'h01;
  wire [`EXEC_DATA_W-1:0] r_inc = m + 8'h01;
  wire [`EXEC_DATA_W-1:0] r_or_m = acc | m;
  wire [`EXEC_DATA_W-1:0] r_or_x = acc | x;
  wire [`EXEC_DATA_W-1:0] r_rl = {m[6:0], m[7]};

  // decimal adjust, low nibble first
  wire [4:0] lo_in = {1'b0, acc[3:0]};
  wire lo_fix = (lo_in > `EXEC_BCD_LIMIT) | status.aux_carry_flag;
  wire [4:0] lo_sum = lo_fix ? lo_in + `EXEC_BCD_FIX : lo_in;
  wire nibble_adjust_carry = lo_fix & ~status.aux_carry_flag;
  // high nibble takes the internal carry, then a fix if needed
  wire [4:0] hi_in = {1'b0, acc[7:4]} + {4'h0, nibble_adjust_carry};
  wire hi_fix = (hi_in > `EXEC_BCD_LIMIT) | status.carry_flag;
  wire [4:0] hi_sum = hi_fix ? hi_in + `EXEC_BCD_FIX : hi_in;
  wire [`EXEC_DATA_W-1:0] r_daa = {hi_sum[3:0], lo_sum[3:0]};

  ////////////////////////////////////////////////////////////////////////
  // per-operation effects
  logic next_acc_we; // accumulator loads
  logic [`EXEC_DATA_W-1:0] next_acc; // accumulator value
  logic next_mem_we; // memory write strobe
  logic [`EXEC_DATA_W-1:0] next_mem; // memory write value
  logic next_zero_we; // zero flag updates
  logic [`EXEC_DATA_W-1:0] zero_src; // byte the zero flag is taken from
  logic next_pc_jump; // pc loads the address field

  // one-hot effect selection; flags untouched unless named
  always_comb begin
    next_acc_we = 1'b0;
    next_acc = acc;
    next_mem_we = 1'b0;
    next_mem = `EXEC_MEM_RST;
    next_zero_we = 1'b0;
    zero_src = `EXEC_MEM_RST;
    next_pc_jump = 1'b0;
    unique case (op)
      OP_COMPLEMENT_MEM: begin
        next_mem_we = 1'b1;
        next_mem = r_cpl;
        next_zero_we = 1'b1;
        zero_src = r_cpl;
      end
      OP_COMPLEMENT_TO_ACC: begin
        next_acc_we = 1'b1;
        next_acc = r_cpl;
        next_zero_we = 1'b1;
        zero_src = r_cpl;
      end
      OP_DECIMAL_ADJUST: begin
        next_mem_we = 1'b1;
        next_mem = r_daa;
      end
      OP_DECREMENT_MEM: begin
        next_mem_we = 1'b1;
        next_mem = r_dec;
        next_zero_we = 1'b1;
        zero_src = r_dec;
      end
      OP_DECREMENT_TO_ACC: begin
        next_acc_we = 1'b1;
        next_acc = r_dec;
        next_zero_we = 1'b1;
        zero_src = r_dec;
      end
      OP_INCREMENT_MEM: begin
        next_mem_we = 1'b1;
        next_mem = r_inc;
        next_zero_we = 1'b1;
        zero_src = r_inc;
      end
      OP_INCREMENT_TO_ACC: begin
        next_acc_we = 1'b1;
        next_acc = r_inc;
        next_zero_we = 1'b1;
        zero_src = r_inc;
      end
      OP_DIRECT_JUMP: begin
        next_pc_jump = 1'b1;
      end
      OP_MOVE_MEM_TO_ACC: begin
        next_acc_we = 1'b1;
        next_acc = m;
      end
      OP_MOVE_IMM_TO_ACC, OP_RETURN_WITH_VALUE: begin
        next_acc_we = 1'b1;
        next_acc = x;
      end
      OP_MOVE_ACC_TO_MEM: begin
        next_mem_we = 1'b1;
        next_mem = acc;
      end
      OP_OR_MEM_TO_ACC: begin
        next_acc_we = 1'b1;
        next_acc = r_or_m;
        next_zero_we = 1'b1;
        zero_src = r_or_m;
      end
      OP_OR_IMM_TO_ACC: begin
        next_acc_we = 1'b1;
        next_acc = r_or_x;
        next_zero_we = 1'b1;
        zero_src = r_or_x;
      end
      OP_OR_TO_MEMORY: begin
        next_mem_we = 1'b1;
        next_mem = r_or_m;
        next_zero_we = 1'b1;
        zero_src = r_or_m;
      end
      OP_ROTATE_LEFT_MEM: begin
        next_mem_we = 1'b1;
        next_mem = r_rl;
      end
      OP_ROTATE_LEFT_TO_ACC: begin
        next_acc_we = 1'b1;
        next_acc = r_rl;
      end
      // no data effect: nop, watchdog ops, halt, plain and interrupt returns
      default: begin
        next_acc_we = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // watchdog chain; overflow of the counter is the timeout event
  wire pre_wrap = &wdt_pre;
  wire wdt_overflow = pre_wrap & (&watchdog_counter);

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      wdt_pre <= `EXEC_WDT_PRE_CLEAR;
      watchdog_counter <= `EXEC_WDT_CLEAR;
    end else if (wdt_clear) begin
      wdt_pre <= `EXEC_WDT_PRE_CLEAR;
      watchdog_counter <= `EXEC_WDT_CLEAR;
    end else begin
      wdt_pre <= wdt_pre + 8'h01;
      watchdog_counter <= pre_wrap ? watchdog_counter + 8'h01 : watchdog_counter;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // preclear markers; both drop once the pair completes
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      mark_first <= 1'b0;
      mark_second <= 1'b0;
    end else if (pair_done | is_single | is_halt) begin
      mark_first <= 1'b0;
      mark_second <= 1'b0;
    end else begin
      mark_first <= mark_first | is_pre1;
      mark_second <= mark_second | is_pre2;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wake pin synchroniser
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
    end else begin
      wake_meta <= I_WAKE;
      wake_sync <= wake_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer: returns take a second cycle, halt waits for wake
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      state <= ST_EXEC;
    end else begin
      unique case (state)
        ST_EXEC: begin
          if (pop) begin
            state <= ST_RETURN;
          end else if (is_halt) begin
            state <= ST_HALT;
          end
        end
        ST_RETURN: begin
          state <= ST_EXEC;
        end
        ST_HALT: begin
          if (wake_sync) begin
            state <= ST_EXEC;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // program counter
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      pc <= `EXEC_PC_RST;
    end else if (state == ST_RETURN) begin
      pc <= stack_data;
    end else if (take & next_pc_jump) begin
      pc <= I_OP.addr;
    end else if (take & ~is_ret) begin
      pc <= pc + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // accumulator and memory write port
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      acc <= `EXEC_ACC_RST;
      mem_we <= 1'b0;
      mem_wdata <= `EXEC_MEM_RST;
    end else begin
      acc <= (take & next_acc_we) ? next_acc : acc;
      mem_we <= take & next_mem_we;
      mem_wdata <= (take & next_mem_we) ? next_mem : mem_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flags; a watchdog timeout beats any clear in the same cycle
  wire flag_clear = is_single | pair_done;

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      status <= '0;
      gie <= 1'b0;
    end else begin
      if (wdt_overflow) begin
        status.timeout_flag <= 1'b1;
      end else if (flag_clear | is_halt) begin
        status.timeout_flag <= 1'b0;
      end
      if (is_halt) begin
        status.powerdown_flag <= 1'b1;
      end else if (flag_clear) begin
        status.powerdown_flag <= 1'b0;
      end
      if (take & next_zero_we) begin
        status.zero_flag <= (zero_src == 8'h00);
      end
      if (take & (op == OP_DECIMAL_ADJUST) & hi_fix) begin
        status.carry_flag <= 1'b1;
      end
      // interrupt return sets, interrupt entry clears; set wins
      if (take & (op == OP_INTERRUPT_RETURN)) begin
        gie <= 1'b1;
      end else if (I_GIE_CLEAR) begin
        gie <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // return stack
  exec_stack u_stack (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_push(I_STACK_PUSH),
    .i_push_data(I_STACK_PUSH_PC),
    .i_pop(pop),
    .o_pop_data(stack_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // outputs; clock gating itself lives outside this block
  assign O_OP_READY = (state == ST_EXEC);
  assign O_MEM_WE = mem_we;
  assign O_MEM_WDATA = mem_wdata;
  assign O_PC = pc;
  assign O_ACC = acc;
  assign O_STATUS = status;
  assign O_GLOBAL_INTERRUPT_ENABLE = gie;
  assign O_SYSCLK_RUN = (state != ST_HALT);
  assign O_WATCHDOG_TIMEOUT = status.timeout_flag;
  assign O_WATCHDOG_COUNTER = watchdog_counter;
  assign O_PRECLEAR_MARKS = {mark_second, mark_first};

endmodule : exec_core

// [logic/exec_cfg.svh]
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH

// datapath widths
`define EXEC_DATA_W 8
`define EXEC_PC_W 12
`define EXEC_OP_W 5

// return stack shape
`define EXEC_STACK_DEPTH 8
`define EXEC_STACK_PTR_W 3

// decimal adjust figures
`define EXEC_BCD_LIMIT 5'h09
`define EXEC_BCD_FIX 5'h06

// watchdog chain widths and cleared value
`define EXEC_WDT_W 8
`define EXEC_WDT_PRE_W 8
`define EXEC_WDT_CLEAR 8'h00
`define EXEC_WDT_PRE_CLEAR 8'h00

// reset values
`define EXEC_PC_RST 12'h000
`define EXEC_ACC_RST 8'h00
`define EXEC_MEM_RST 8'h00

`endif

// [logic/exec_pkg.sv]
`include "exec_cfg.svh"

package exec_pkg;

  // decoded operation presented by the fetch/decode stage
  typedef enum logic [`EXEC_OP_W-1:0] {
    OP_NOP = 5'h00,
    OP_WATCHDOG_CLEAR_SINGLE = 5'h01,
    OP_WATCHDOG_PRECLEAR_FIRST = 5'h02,
    OP_WATCHDOG_PRECLEAR_SECOND = 5'h03,
    OP_COMPLEMENT_MEM = 5'h04,
    OP_COMPLEMENT_TO_ACC = 5'h05,
    OP_DECIMAL_ADJUST = 5'h06,
    OP_DECREMENT_MEM = 5'h07,
    OP_DECREMENT_TO_ACC = 5'h08,
    OP_INCREMENT_MEM = 5'h09,
    OP_INCREMENT_TO_ACC = 5'h0a,
    OP_HALT = 5'h0b,
    OP_DIRECT_JUMP = 5'h0c,
    OP_MOVE_MEM_TO_ACC = 5'h0d,
    OP_MOVE_IMM_TO_ACC = 5'h0e,
    OP_MOVE_ACC_TO_MEM = 5'h0f,
    OP_OR_MEM_TO_ACC = 5'h10,
    OP_OR_IMM_TO_ACC = 5'h11,
    OP_OR_TO_MEMORY = 5'h12,
    OP_SUBROUTINE_RETURN = 5'h13,
    OP_RETURN_WITH_VALUE = 5'h14,
    OP_INTERRUPT_RETURN = 5'h15,
    OP_ROTATE_LEFT_MEM = 5'h16,
    OP_ROTATE_LEFT_TO_ACC = 5'h17
  } op_t;

  // one decoded instruction
  typedef struct packed {
    op_t op;
    logic [`EXEC_DATA_W-1:0] imm;
    logic [`EXEC_PC_W-1:0] addr;
  } instr_t;

  // status flags
  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
    logic overflow_flag;
    logic zero_flag;
    logic aux_carry_flag;
    logic carry_flag;
  } status_t;

  // sequencer states, gray along exec -> return -> halt
  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_RETURN = 2'b01,
    ST_HALT = 2'b11
  } state_t;

endpackage : exec_pkg

// [logic/exec_stack.sv]
`timescale 1ns/1ps
`include "exec_cfg.svh"

module exec_stack
  import exec_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // push side
  input wire logic i_push,
  input wire logic [`EXEC_PC_W-1:0] i_push_data,
  // pop side, data registered one cycle later
  input wire logic i_pop,
  output logic [`EXEC_PC_W-1:0] o_pop_data
);

  logic [`EXEC_STACK_PTR_W-1:0] ptr; // next free slot, wraps like a circular stack
  logic [`EXEC_PC_W-1:0] entry [`EXEC_STACK_DEPTH]; // stored return addresses
  wire [`EXEC_STACK_PTR_W-1:0] top = ptr - 3'h1; // most recent entry
  wire do_push = i_push & ~i_pop; // pop wins so a return is never corrupted

  ////////////////////////////////////////////////////////////////////////
  // pointer moves up on push, down on pop
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ptr <= 3'h0;
    end else if (i_pop) begin
      ptr <= top;
    end else if (do_push) begin
      ptr <= ptr + 3'h1;
    end
  end

  // registered read of the top entry
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pop_data <= `EXEC_PC_RST;
    end else if (i_pop) begin
      o_pop_data <= entry[top];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one storage word per level; overflow overwrites the oldest
  genvar g;
  generate
    for (g = 0; g < `EXEC_STACK_DEPTH; g++) begin : g_level
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          entry[g] <= `EXEC_PC_RST;
        end else if (do_push && ptr == 3'(g)) begin
          entry[g] <= i_push_data;
        end
      end
    end
  endgenerate

endmodule : exec_stack

// [sim/exec_core_sva.sv]
`timescale 1ns/1ps
`include "exec_cfg.svh"

module exec_core_sva
  import exec_pkg::*;
(
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // request side
  input wire logic I_OP_VALID,
  input wire instr_t I_OP,
  input wire logic O_OP_READY,
  input wire logic [`EXEC_DATA_W-1:0] I_MEM_RDATA,
  // results
  input wire logic O_MEM_WE,
  input wire logic [`EXEC_DATA_W-1:0] O_MEM_WDATA,
  input wire logic [`EXEC_PC_W-1:0] O_PC,
  input wire logic [`EXEC_DATA_W-1:0] O_ACC,
  input wire status_t O_STATUS,
  input wire logic O_GLOBAL_INTERRUPT_ENABLE,
  input wire logic O_SYSCLK_RUN,
  input wire logic [`EXEC_WDT_W-1:0] O_WATCHDOG_COUNTER
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);

  ////////////////////////////////////////////////////////////////////////////
  // request taken at this edge
  wire tk = I_OP_VALID && O_OP_READY;
  op_t op; // decoded operation
  assign op = I_OP.op;
  // arithmetic flags only; timeout may be set by the watchdog at any time
  logic [3:0] ar;
  assign ar = {O_STATUS.overflow_flag, O_STATUS.zero_flag,
               O_STATUS.aux_carry_flag, O_STATUS.carry_flag};
  // memory byte seen at the taking edge, kept so it can be sliced
  logic [7:0] rd_q;
  always_ff @(posedge I_REF_CLK) begin
    rd_q <= I_MEM_RDATA;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_ret_gap: assert property (tk && op inside {OP_SUBROUTINE_RETURN,
    OP_RETURN_WITH_VALUE, OP_INTERRUPT_RETURN} |=> !O_OP_READY ##1 O_OP_READY)
    else $error("return gap wrong");
  a_jump_load: assert property (tk && op == OP_DIRECT_JUMP |=>
    O_PC == $past(I_OP.addr) && $stable(ar)) else $error("jump target wrong");
  a_nop_step: assert property (tk && op == OP_NOP |=>
    O_PC == $past(O_PC) + 12'h001 && $stable(ar) && !O_MEM_WE) else $error("nop wrong");
  a_inc_acc: assert property (tk && op == OP_INCREMENT_TO_ACC |=>
    O_ACC == rd_q + 8'h01 && O_STATUS.zero_flag == (O_ACC == 8'h00) && !O_MEM_WE)
    else $error("increment wrong");
  a_cpl_mem: assert property (tk && op == OP_COMPLEMENT_MEM |=>
    O_MEM_WE && O_MEM_WDATA == ~rd_q && $stable(O_ACC)) else $error("complement wrong");
  a_move_imm: assert property (tk && op == OP_MOVE_IMM_TO_ACC |=>
    O_ACC == $past(I_OP.imm) && $stable(ar)) else $error("move wrong");
  a_interrupt_return_gie: assert property (tk && op == OP_INTERRUPT_RETURN |=>
    O_GLOBAL_INTERRUPT_ENABLE) else $error("interrupt enable not set");
  a_halt_stop: assert property (tk && op == OP_HALT |=> !O_SYSCLK_RUN &&
    !O_OP_READY && O_STATUS.powerdown_flag && !O_STATUS.timeout_flag &&
    O_WATCHDOG_COUNTER == 8'h00) else $error("halt entry wrong");
  a_rl_mem: assert property (tk && op == OP_ROTATE_LEFT_MEM |=>
    O_MEM_WE && O_MEM_WDATA == {rd_q[6:0], rd_q[7]} && $stable(ar))
    else $error("rotate wrong");
  a_or_mem: assert property (tk && op == OP_OR_TO_MEMORY |=> O_MEM_WE &&
    O_MEM_WDATA == ($past(O_ACC) | rd_q) && O_STATUS.zero_flag == (O_MEM_WDATA == 8'h00))
    else $error("or to memory wrong");

  // main scenarios reached
  c_halt: cover property (tk && op == OP_HALT);
  c_ret: cover property (tk && op == OP_SUBROUTINE_RETURN);
  c_or_mem: cover property (tk && op == OP_OR_TO_MEMORY);
endmodule : exec_core_sva

bind exec_core exec_core_sva u_sva (.I_REF_CLK, .I_RST, .I_OP_VALID, .I_OP, .O_OP_READY,
  .I_MEM_RDATA, .O_MEM_WE, .O_MEM_WDATA, .O_PC, .O_ACC, .O_STATUS,
  .O_GLOBAL_INTERRUPT_ENABLE, .O_SYSCLK_RUN, .O_WATCHDOG_COUNTER);

// [sim/exec_dmem_model.sv]
`timescale 1ns/1ps

// small data memory; the bench supplies the address the core has no port for
module exec_dmem_model (
  // clock
  input wire logic i_clk,
  // access
  input wire logic [3:0] i_addr,
  input wire logic i_we,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:15]; // unwritten bytes read unknown on purpose
  assign o_rdata = mem[i_addr];
  // write lands on the edge that ends the strobe cycle
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end
endmodule : exec_dmem_model

// [sim/mcu_instruction_execute_subset_tb.sv]
`timescale 1ns/1ps
`include "exec_cfg.svh"

module mcu_instruction_execute_subset_tb
  import exec_pkg::*;
;
  logic ref_clk, rst, valid, ready, we, gie, run, wake, gclr, push, tmo;
  instr_t op_in;
  logic [3:0] ma; // data memory address for the current request
  logic [7:0] rd, wd, acc;
  logic [11:0] pc, push_pc, h;
  logic [7:0] wdc;
  logic [1:0] marks;
  status_t stat;
  int err_total, samples_checked;
  op_t rops[3] = '{OP_SUBROUTINE_RETURN, OP_RETURN_WITH_VALUE, OP_INTERRUPT_RETURN};
  op_t fo[2] = '{OP_WATCHDOG_PRECLEAR_FIRST, OP_WATCHDOG_PRECLEAR_SECOND};

  exec_core u_dut (.I_REF_CLK(ref_clk), .I_RST(rst), .I_OP_VALID(valid), .I_OP(op_in),
    .O_OP_READY(ready), .I_MEM_RDATA(rd), .O_MEM_WE(we), .O_MEM_WDATA(wd),
    .I_STACK_PUSH(push), .I_STACK_PUSH_PC(push_pc), .I_WAKE(wake), .I_GIE_CLEAR(gclr),
    .O_PC(pc), .O_ACC(acc), .O_STATUS(stat), .O_GLOBAL_INTERRUPT_ENABLE(gie),
    .O_SYSCLK_RUN(run), .O_WATCHDOG_TIMEOUT(tmo), .O_WATCHDOG_COUNTER(wdc),
    .O_PRECLEAR_MARKS(marks));
  exec_dmem_model u_mem (.i_clk(ref_clk), .i_addr(ma), .i_we(we), .i_wdata(wd), .o_rdata(rd));

  ////////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // wide enough for the longest packed compare, so no bit is lost
  task automatic chk(logic [31:0] s, logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("ERROR t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // one request, held from a falling edge until taken; results settle by the next
  task automatic ex(op_t o, logic [7:0] im = 8'h00, logic [3:0] m = 4'h0);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (ready !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 20) err_total++;
    valid = 1'b1;
    op_in = '{o, im, {4'h5, im}};
    ma = m;
    @(negedge ref_clk);
    valid = 1'b0;
  endtask : ex

  // byte into memory through the accumulator
  task automatic put(logic [3:0] m, logic [7:0] v);
    ex(OP_MOVE_IMM_TO_ACC, v);
    ex(OP_MOVE_ACC_TO_MEM, 8'h00, m);
  endtask : put

  // memory byte once the pending write has landed
  task automatic mm(logic [3:0] m, logic [7:0] e);
    @(negedge ref_clk);
    chk(u_mem.mem[m], e);
  endtask : mm

  // wake level until the core takes requests again, then settle the synchroniser
  task automatic wk();
    @(negedge ref_clk);
    wake = 1'b1;
    for (int n = 0; n < 20 && ready !== 1'b1; n++) @(negedge ref_clk);
    chk(ready, 1'b1);
    wake = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask : wk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    finish_test();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    valid = 1'b0;
    op_in = '0;
    ma = 4'h0;
    wake = 1'b0;
    gclr = 1'b0;
    push = 1'b0;
    push_pc = 12'h000;
    err_total = 0;
    samples_checked = 0;
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk) rst = 1'b0;
    chk({pc, acc}, 20'h0);
    chk({stat, ready, run, gie}, 9'b000000110);
    // increment and decrement, in place and to the accumulator
    put(4'h1, 8'h0f);
    ex(OP_INCREMENT_TO_ACC, 8'h00, 4'h1);
    chk({acc, stat.zero_flag}, {8'h10, 1'b0});
    mm(4'h1, 8'h0f);
    put(4'h2, 8'h01);
    ex(OP_DECREMENT_MEM, 8'h00, 4'h2);
    chk({acc, stat.zero_flag}, {8'h01, 1'b1});
    mm(4'h2, 8'h00);
    ex(OP_DECREMENT_TO_ACC, 8'h00, 4'h2);
    chk({acc, stat.zero_flag}, {8'hff, 1'b0});
    mm(4'h2, 8'h00);
    ex(OP_INCREMENT_MEM, 8'h00, 4'h2);
    mm(4'h2, 8'h01);
    put(4'h3, 8'hff);
    ex(OP_INCREMENT_MEM, 8'h00, 4'h3);
    chk(stat.zero_flag, 1'b1);
    mm(4'h3, 8'h00);
    $display("inc dec done");
    // complement in place and to the accumulator
    put(4'h4, 8'h5a);
    ex(OP_COMPLEMENT_MEM, 8'h00, 4'h4);
    chk(stat.zero_flag, 1'b0);
    mm(4'h4, 8'ha5);
    put(4'h5, 8'hff);
    ex(OP_COMPLEMENT_TO_ACC, 8'h00, 4'h5);
    chk({acc, stat.zero_flag}, {8'h00, 1'b1});
    mm(4'h5, 8'hff);
    $display("complement done");
    // decimal adjust: plain, both nibbles fixed, high fixed by carry alone
    for (int k = 0; k < 3; k++) begin
      logic [7:0] av, rv;
      av = (k == 0) ? 8'h23 : (k == 1) ? 8'h9a : 8'h45;
      rv = (k == 0) ? 8'h23 : (k == 1) ? 8'h00 : 8'ha5;
      ex(OP_MOVE_IMM_TO_ACC, av);
      ex(OP_DECIMAL_ADJUST, 8'h00, 4'h6);
      chk({acc, stat.zero_flag}, {av, 1'b1});
      chk(stat.carry_flag, k != 0);
      mm(4'h6, rv);
    end
    $display("decimal adjust done");
    // or, to accumulator and to memory, then rotates
    put(4'h7, 8'h81);
    ex(OP_MOVE_IMM_TO_ACC, 8'h24);
    ex(OP_OR_MEM_TO_ACC, 8'h00, 4'h7);
    chk({acc, stat.zero_flag}, {8'ha5, 1'b0});
    ex(OP_MOVE_IMM_TO_ACC, 8'h02);
    ex(OP_OR_TO_MEMORY, 8'h00, 4'h7);
    chk(acc, 8'h02);
    mm(4'h7, 8'h83);
    ex(OP_MOVE_IMM_TO_ACC, 8'h00);
    ex(OP_OR_IMM_TO_ACC, 8'h00);
    chk(stat.zero_flag, 1'b1);
    ex(OP_ROTATE_LEFT_MEM, 8'h00, 4'h7);
    chk({stat.zero_flag, stat.carry_flag}, 2'b11);
    mm(4'h7, 8'h07);
    ex(OP_MOVE_MEM_TO_ACC, 8'h00, 4'h4);
    chk({acc, stat.zero_flag}, {8'ha5, 1'b1});
    ex(OP_ROTATE_LEFT_TO_ACC, 8'h00, 4'h4);
    chk(acc, 8'h4b);
    mm(4'h4, 8'ha5);
    $display("or rotate done");
    // jump, no-operation, then the three returns back to back with pushes
    ex(OP_DIRECT_JUMP, 8'hbc);
    chk({pc, stat.carry_flag}, {12'h5bc, 1'b1});
    ex(OP_NOP);
    chk({pc, acc}, {12'h5bd, 8'h4b});
    for (int k = 0; k < 3; k++) begin
      @(negedge ref_clk);
      push = 1'b1;
      push_pc = 12'h123 + 12'(k);
      @(negedge ref_clk) push = 1'b0;
      ex(rops[k], 8'h3c);
      chk(ready, 1'b0);
      @(negedge ref_clk);
      chk({pc, ready}, {12'h123 + 12'(k), 1'b1});
    end
    chk({acc, gie, stat.carry_flag}, {8'h3c, 1'b1, 1'b1});
    // interrupt entry pulse must drop the enable that the return raised
    @(negedge ref_clk) gclr = 1'b1;
    @(negedge ref_clk) gclr = 1'b0;
    chk(gie, 1'b0);
    $display("flow done");
    // halt and watchdog clears: pair both ways, then the single clear
    for (int k = 0; k < 3; k++) begin
      h = pc;
      ex(OP_HALT);
      chk({run, stat.powerdown_flag, stat.timeout_flag, tmo}, 4'b0100);
      chk({pc, wdc}, {h + 12'h001, 8'h00});
      wk();
      if (k == 2) begin
        ex(OP_WATCHDOG_CLEAR_SINGLE);
      end else begin
        ex(fo[k]);
        chk({marks, stat.powerdown_flag}, {k[0], ~k[0], 1'b1});
        ex(OP_NOP);
        ex(fo[1 - k]);
      end
      chk({marks, stat.powerdown_flag, stat.timeout_flag}, 4'h0);
      chk(wdc, 8'h00);
    end
    $display("watchdog done");
    finish_test();
  end
endmodule : mcu_instruction_execute_subset_tb
